// >>> logic/scm_sysclk_ctrl.sv
// The APB slave port and the register offsets are this design's own decisions.
`default_nettype none
module scm_sysclk_ctrl
  import scm_pkg::*;
#(
  parameter int SETTLE_CYC = FAST_RC_SETTLE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator sources
  input wire logic fast_rc_clk,
  input wire logic slow_rc_clk,
  // core side
  input wire logic cpu_halt,
  input wire logic watchdog_enable,
  // clock outputs and status
  output scm_clk_t clk_out,
  output logic [1:0] fast_rc_freq_sel,
  output scm_mode_t mode
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] sysclk_select_r;
  logic fast_osc_halt_keep_r, slow_osc_halt_keep_r;
  logic [1:0] fast_rc_freq_select_r;
  logic fast_rc_enable_r, fast_rc_stable_flag_r;
  logic [15:0] settle_cnt_r;
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_select_r <= SYSCLK_CTRL_RST[7:5];
      fast_osc_halt_keep_r <= SYSCLK_CTRL_RST[FAST_KEEP_BIT];
      slow_osc_halt_keep_r <= SYSCLK_CTRL_RST[SLOW_KEEP_BIT];
      fast_rc_freq_select_r <= FAST_RC_CTRL_RST[3:2];
      fast_rc_enable_r <= FAST_RC_CTRL_RST[ENABLE_BIT];
    end else if (wr_en && paddr == SYSCLK_CTRL_ADDR) begin
      sysclk_select_r <= pwdata[SEL_LSB +: 3];
      fast_osc_halt_keep_r <= pwdata[FAST_KEEP_BIT];
      slow_osc_halt_keep_r <= pwdata[SLOW_KEEP_BIT];
    end else if (wr_en && paddr == FAST_RC_CTRL_ADDR) begin
      fast_rc_freq_select_r <= pwdata[FREQ_LSB +: 2];
      fast_rc_enable_r <= pwdata[ENABLE_BIT];
    end
  end

  // read data latched in setup so prdata is a flop; zero-wait slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        SYSCLK_CTRL_ADDR: prdata <= {24'h0, sysclk_select_r, 3'h0,
                                     fast_osc_halt_keep_r, slow_osc_halt_keep_r};
        FAST_RC_CTRL_ADDR: prdata <= {28'h0, fast_rc_freq_select_r,
                                      fast_rc_stable_flag_r, fast_rc_enable_r};
        MODE_STAT_ADDR: prdata <= {29'h0, mode};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != SYSCLK_CTRL_ADDR &&
                 paddr != FAST_RC_CTRL_ADDR && paddr != MODE_STAT_ADDR;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  scm_mode_t mode_nxt;
  always_comb begin
    mode_nxt = MODE_FAST;
    if (!cpu_halt) begin
      mode_nxt = (sysclk_select_r == SEL_SLOW) ? MODE_SLOW : MODE_FAST;
    end else begin
      case ({fast_osc_halt_keep_r, slow_osc_halt_keep_r})
        2'b00: mode_nxt = MODE_SLEEP;
        2'b01: mode_nxt = MODE_CPU_OFF_SLOW;
        2'b11: mode_nxt = MODE_CPU_OFF_ALL;
        2'b10: mode_nxt = MODE_CPU_OFF_FAST;
        default: mode_nxt = MODE_SLEEP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode <= MODE_FAST;
    else mode <= mode_nxt;
  end

  // ----------------------------------------
  // oscillator enables and gates
  // ----------------------------------------
  logic fast_on_nxt, slow_on_nxt, slow_per_nxt, sys_on_nxt;
  always_comb begin
    fast_on_nxt = 1'b1;
    slow_on_nxt = 1'b1;
    slow_per_nxt = 1'b1;
    sys_on_nxt = 1'b1;
    case (mode_nxt)
      MODE_FAST: fast_on_nxt = 1'b1;
      MODE_SLOW: fast_on_nxt = fast_rc_enable_r;
      MODE_SLEEP: begin
        fast_on_nxt = 1'b0;
        slow_per_nxt = 1'b0;
        sys_on_nxt = 1'b0;
        slow_on_nxt = watchdog_enable;
      end
      MODE_CPU_OFF_SLOW: begin
        fast_on_nxt = 1'b0;
        sys_on_nxt = (sysclk_select_r == SEL_SLOW);
      end
      MODE_CPU_OFF_ALL: fast_on_nxt = 1'b1;
      MODE_CPU_OFF_FAST: begin
        slow_per_nxt = 1'b0;
        slow_on_nxt = watchdog_enable;
        sys_on_nxt = (sysclk_select_r != SEL_SLOW);
      end
      default: fast_on_nxt = 1'b1;
    endcase
    fast_on_nxt = fast_on_nxt && fast_rc_enable_r;
  end

  logic fast_rc_on_r, slow_rc_on_r, cpu_clk_en_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_on_r <= 1'b1;
      slow_rc_on_r <= 1'b1;
      cpu_clk_en_r <= 1'b1;
      fast_rc_freq_sel <= 2'h0;
    end else begin
      fast_rc_on_r <= fast_on_nxt;
      slow_rc_on_r <= slow_on_nxt;
      cpu_clk_en_r <= !cpu_halt;
      // 11 maps back to the 4 MHz trim
      fast_rc_freq_sel <= (fast_rc_freq_select_r == 2'h3) ? 2'h0
                                                          : fast_rc_freq_select_r;
    end
  end

  // ----------------------------------------
  // stable flag
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_r <= 16'h0000;
      fast_rc_stable_flag_r <= 1'b0;
    end else if (!fast_on_nxt) begin
      settle_cnt_r <= 16'h0000;
      fast_rc_stable_flag_r <= 1'b0;
    end else if (settle_cnt_r >= 16'(SETTLE_CYC - 1)) begin
      fast_rc_stable_flag_r <= 1'b1;
    end else begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // clock generation on the fast rc domain
  // ----------------------------------------
  // divider and select flops run on the fast rc edge; the select is
  // applied only at a full divider period boundary so no fast tap pulse is shortened
  logic [5:0] div_r;
  logic [2:0] sel_fast_r;
  always_ff @(posedge fast_rc_clk or negedge presetn) begin
    if (!presetn) div_r <= 6'h00;
    else div_r <= div_r + 6'h01;
  end

  // one tap per divide ratio, tap 0 is the undivided fast clock
  logic [6:0] tap;
  assign tap[0] = fast_rc_clk;
  genvar gi;
  generate
    for (gi = 1; gi < 7; gi++) begin : g_tap
      assign tap[gi] = div_r[gi-1];
    end
  endgenerate

  logic div_q;
  always_comb begin
    if (sel_fast_r == SEL_SLOW) div_q = slow_rc_clk;
    else div_q = tap[sel_fast_r];
  end

  logic wrap;
  assign wrap = (div_r == 6'h3F);
  always_ff @(posedge fast_rc_clk or negedge presetn) begin
    if (!presetn) sel_fast_r <= 3'h0;
    else if (wrap) sel_fast_r <= sysclk_select_r;
  end

  always_comb begin
    clk_out.fast_rc_on = fast_rc_on_r;
    clk_out.slow_rc_on = slow_rc_on_r;
    clk_out.cpu_clk_en = cpu_clk_en_r;
    clk_out.fast_clk = fast_rc_clk && fast_rc_on_r;
    clk_out.slow_clk = slow_rc_clk && slow_rc_on_r;
    clk_out.sys_clk = div_q && sys_on_nxt;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SLEEP_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_SLEEP |-> !clk_out.fast_rc_on) else $error("fast on in sleep");
  AST_RUN_CPU: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!cpu_halt) |-> clk_out.cpu_clk_en) else $error("cpu gated while running");
  AST_EN_GATES: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(fast_rc_enable_r) |-> !clk_out.fast_rc_on) else $error("fast on while off");
  AST_WATCHDOG_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
    $past(watchdog_enable) |-> clk_out.slow_rc_on) else $error("slow off with watchdog");
  AST_STABLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fast_rc_enable_r) |-> !fast_rc_stable_flag_r) else $error("stable not cleared");
  AST_ALL_KEEP_ON: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_CPU_OFF_ALL && $past(fast_rc_enable_r) |-> clk_out.fast_rc_on)
    else $error("fast off with all clocks kept");
  AST_SLOW_KEEP_FAST: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_CPU_OFF_SLOW |-> !clk_out.fast_rc_on) else $error("fast on, slow kept only");
  AST_RUN_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(cpu_halt) |-> mode inside {MODE_FAST, MODE_SLOW}) else $error("halt mode while run");
endmodule // scm_sysclk_ctrl
`default_nettype wire

// >>> logic/scm_pkg.sv
`default_nettype none
package scm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] SYSCLK_CTRL_ADDR = 12'h000;
  localparam logic [11:0] FAST_RC_CTRL_ADDR = 12'h004;
  localparam logic [11:0] MODE_STAT_ADDR = 12'h008;
  localparam logic [7:0] SYSCLK_CTRL_RST = 8'h00;
  localparam logic [7:0] FAST_RC_CTRL_RST = 8'h01;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SEL_LSB = 5;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int FREQ_LSB = 2;
  localparam int STABLE_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int FAST_RC_SETTLE_NS = 16000;
  localparam int FAST_RC_SETTLE_CYC =
    (FAST_RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_FAST = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_CPU_OFF_SLOW = 3'b011,
    MODE_CPU_OFF_ALL = 3'b100,
    MODE_CPU_OFF_FAST = 3'b101
  } scm_mode_t;
  typedef struct packed {
    logic sys_clk;
    logic fast_clk;
    logic slow_clk;
    logic slow_rc_on;
    logic fast_rc_on;
    logic cpu_clk_en;
  } scm_clk_t;
endpackage
`default_nettype wire

// >>> verification/scm_sysclk_ctrl_bench.sv
`default_nettype none
module scm_sysclk_ctrl_bench
  import scm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fast_rc_clk = 1'b0;
  logic slow_rc_clk = 1'b0;
  logic cpu_halt = 1'b0;
  logic watchdog_enable = 1'b0;
  logic [1:0] div_q = 2'h0;
  logic [1:0] fast_rc_freq_sel;
  scm_clk_t clk_out;
  scm_mode_t mode;
  scm_mode_t hm [4] = '{MODE_SLEEP, MODE_CPU_OFF_SLOW, MODE_CPU_OFF_FAST, MODE_CPU_OFF_ALL};
  int failures = 0;
  int checks_done = 0;
  logic [31:0] r;
  logic e;
  int n;

  scm_sysclk_ctrl #(.SETTLE_CYC(4)) scm_sysclk_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk), .cpu_halt(cpu_halt),
    .watchdog_enable(watchdog_enable), .clk_out(clk_out), .fast_rc_freq_sel(fast_rc_freq_sel),
    .mode(mode)
  );

  // ----------------------------------------
  // clocks: fast osc at half pclk, slow at an eighth
  // ----------------------------------------
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    fast_rc_clk <= ~fast_rc_clk;
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) slow_rc_clk <= ~slow_rc_clk;
  end

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles to the next rising edge of sys_clk, lim if none
  task automatic rise(input int lim, output int c);
    logic p;
    c = 0;
    p = 1'b1;
    while (!(p === 1'b0 && clk_out.sys_clk === 1'b1) && c < lim) begin
      p = clk_out.sys_clk;
      @(negedge pclk);
      c++;
    end
  endtask

  task automatic t_regs();
    apb(0, SYSCLK_CTRL_ADDR, 0);
    chk(r === 32'h0, "sysclk reset");
    apb(0, FAST_RC_CTRL_ADDR, 0);
    chk((r & 32'hFFFFFFFD) === 32'h1, "fast rc reset");
    apb(1, SYSCLK_CTRL_ADDR, 32'hFF);
    apb(0, SYSCLK_CTRL_ADDR, 0);
    chk(r === 32'hE3, "sysclk unused bits");
    apb(1, FAST_RC_CTRL_ADDR, 32'hF2);
    apb(0, FAST_RC_CTRL_ADDR, 0);
    chk(r === 32'h0, "fast rc read-only bits");
    apb(1, 12'h0FC, 32'hFF);
    chk(e === 1'b1, "unmapped write");
    apb(0, 12'h0FC, 0);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    apb(1, FAST_RC_CTRL_ADDR, 32'h1);
    apb(1, SYSCLK_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_freq();
    for (int c = 0; c < 4; c++) begin
      apb(1, FAST_RC_CTRL_ADDR, {28'h0, c[1:0], 2'b01});
      repeat (3) @(posedge pclk);
      chk(fast_rc_freq_sel === ((c == 3) ? 2'h0 : c[1:0]), "freq select");
    end
    apb(1, FAST_RC_CTRL_ADDR, 32'h1);
  endtask

  task automatic t_stable();
    apb(1, SYSCLK_CTRL_ADDR, 32'hE0);
    apb(1, FAST_RC_CTRL_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk(clk_out.fast_rc_on === 1'b0 && mode === MODE_SLOW, "fast off in slow");
    chk(clk_out.fast_clk === 1'b0 && clk_out.slow_clk === slow_rc_clk, "gated clocks");
    apb(1, FAST_RC_CTRL_ADDR, 32'h1);
    apb(0, FAST_RC_CTRL_ADDR, 0);
    chk(r[1] === 1'b0, "stable too early");
    n = 0;
    do begin
      apb(0, FAST_RC_CTRL_ADDR, 0);
      n++;
    end while (r[1] !== 1'b1 && n < 20);
    chk(r[1] === 1'b1 && clk_out.fast_rc_on === 1'b1, "stable never set");
    apb(1, SYSCLK_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_div();
    for (int s = 0; s < 8; s++) begin
      apb(1, SYSCLK_CTRL_ADDR, {24'h0, s[2:0], 5'h00});
      // new ratio is taken only at the divider wrap, up to 128 cycles later
      repeat (140) @(posedge pclk);
      repeat (3) rise(300, n);
      chk(n == ((s == 7) ? 8 : (2 << s)), "sysclk period");
    end
    apb(1, SYSCLK_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_modes();
    logic [2:0] sel;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        sel = (j == 1) ? SEL_SLOW : 3'h0;
        apb(1, SYSCLK_CTRL_ADDR, {24'h0, sel, 3'h0, k[1:0]});
        @(posedge pclk);
        cpu_halt <= 1'b1;
        repeat (4) @(posedge pclk);
        rise(40, n);
        chk(mode === hm[k] && clk_out.cpu_clk_en === 1'b0, "halt mode");
        chk(clk_out.fast_rc_on === k[1], "fast osc halted");
        chk((n < 40) == (k == 3 || (k == 1 && j == 1) || (k == 2 && j == 0)), "halt sysclk");
        if (k != 2) chk(clk_out.slow_rc_on === k[0], "slow osc halted");
        @(posedge pclk);
        cpu_halt <= 1'b0;
        repeat (4) @(posedge pclk);
        rise(40, n);
        chk(mode === ((j == 1) ? MODE_SLOW : MODE_FAST) && n < 40, "run mode");
        chk(clk_out.cpu_clk_en === 1'b1 && clk_out.slow_rc_on === 1'b1, "run clocks");
      end
    end
    apb(1, SYSCLK_CTRL_ADDR, 32'h0);
    @(posedge pclk);
    watchdog_enable <= 1'b1;
    cpu_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    rise(40, n);
    chk(mode === MODE_SLEEP && clk_out.slow_rc_on === 1'b1 && n == 40, "sleep with watchdog");
    @(posedge pclk);
    cpu_halt <= 1'b0;
    watchdog_enable <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_freq();
    t_stable();
    t_div();
    t_modes();
    tally_and_finish();
  end
endmodule // scm_sysclk_ctrl_bench
`default_nettype wire
